// *** rtl/dtm_pkg.sv ***
// dtm_pkg: constants for the dual timer and reload timer block
package dtm_pkg;
  // ****************************************
  // special function register addresses
  // ****************************************
  localparam logic [7:0] ADDR_T0_LOW   = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW   = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH  = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH  = 8'h8d;
  localparam logic [7:0] ADDR_T2_CTRL  = 8'hc8;
  localparam logic [7:0] ADDR_T2_MODE  = 8'hc9;
  localparam logic [7:0] ADDR_T2_RLD_L = 8'hca;
  localparam logic [7:0] ADDR_T2_RLD_H = 8'hcb;
  localparam logic [7:0] ADDR_T2_CNT_L = 8'hcc;
  localparam logic [7:0] ADDR_T2_CNT_H = 8'hcd;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int         T2C_OVF_BIT  = 7;
  localparam int         T2C_RXSEL    = 5;
  localparam int         T2C_TXSEL    = 4;
  localparam int         T2C_RUN      = 2;
  localparam int         T2C_CNTSEL   = 1;
  localparam logic [7:0] T2C_WMASK    = 8'h7e;
  localparam int         T2M_DOWN_EN  = 0;
  localparam int         T2M_RD_FLAG  = 2;
  localparam logic [7:0] T2M_WMASK    = 8'h01;
  localparam int         T2MODE_BAUD  = 1;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] ONE_BYTE     = 8'h01;
  localparam int         MSB          = 7;
  // ****************************************
  // machine cycle: six clocks per cycle
  // ****************************************
  localparam int         STATES_PER_CYCLE = 6;
  localparam int         ACK_T1_DELAY     = 2;
  typedef enum logic [2:0] {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6} dtm_state_t;
endpackage

// *** rtl/dtm_inc_if.sv ***
// dtm_inc_if: shared incrementer request and result bundle
`timescale 1ns/10ps
interface dtm_inc_if;
  logic [7:0] operand;
  logic       enable;
  logic [7:0] result;
  logic       overflow;
  modport user (output operand, output enable, input result, input overflow);
  modport unit (input operand, input enable, output result, output overflow);
endinterface

// *** rtl/dtm_incrementer.sv ***
// dtm_incrementer: the single shared 8-bit incrementer
`timescale 1ns/10ps
module dtm_incrementer
(
  // ****************************************
  // request and result
  // ****************************************
  dtm_inc_if.unit inc
);
  // ****************************************
  // combinational increment
  // ****************************************
  always_comb
  begin
    inc.result   = inc.enable ? inc.operand + dtm_pkg::ONE_BYTE : inc.operand;
    // msb falling from one to zero marks the wrap
    inc.overflow = inc.enable & inc.operand[dtm_pkg::MSB] & ~inc.result[dtm_pkg::MSB];
  end
endmodule

// *** rtl/dtm_sync.sv ***
// dtm_sync: two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dtm_sync #(parameter int W = 3)
(
  // ****************************************
  // clock and control
  // ****************************************
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_ce,
  // ****************************************
  // data
  // ****************************************
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {logic [W-1:0] s1; logic [W-1:0] s2;} dtm_sync_t;
  dtm_sync_t st_ff;
  dtm_sync_t nxt_st;
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_async;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      st_ff <= '0;
    else if (i_ce)
      st_ff <= nxt_st;
  end
  assign o_sync = st_ff.s2;
endmodule

// *** rtl/dtm_timers.sv ***
// dtm_timers: two cascaded timer/counters and the reload timer
// What this block does
// - one shared 8-bit incrementer serves both timers
// - S1 steps timer0 low on tick or edge
// - S2 steps timer0 high on carry, updates flag
// - S3 steps timer1 low on tick or edge
// - S4 steps timer1 high on carry, updates flag
// - overflow is msb going one to zero
// - low carry registered, enables next high step
// - high overflow sets flag and pulse flip-flop
// - interrupt sampling in S2, one cycle late
// - service starts fourth machine cycle after overflow
// - ack clears flag0 at next S2, flag1 at the second S4 after it
// - set beats acknowledge clear in same cycle
// - timer2 auto-reload up/down or baud generator
// - firmware write in S6 beats hardware update, except a timer2 flag set
// - timer2 steps in S1, except in baud counter operation, which steps on a pin edge in any clock
// - timer mode counts once per six clocks
// - timer2 flag bit7 set, firmware clears, baud never
// - bit5 routes timer2 overflow to receive clock
// - bit4 routes timer2 overflow to transmit clock
// - bit2 runs timer2, firmware only
// - bit1 selects counter operation for timer2
// - gate makes timer0 need irq pin high
// - auto-reload mode reloads low from high
// - reload mode loads count from reload bytes on up-count overflow, 16'hffff on a down-count reload match
`timescale 1ns/10ps
module dtm_timers
(
  // ****************************************
  // clock, reset, enable
  // ****************************************
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  // ****************************************
  // special function register port
  // ****************************************
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_sfr_hit,
  // ****************************************
  // timer0/1 configuration from the control and mode registers
  // ****************************************
  input  wire logic       i_timer0_run,
  input  wire logic       i_timer0_gate_enable,
  input  wire logic       i_timer0_counter_sel,
  input  wire logic [1:0] i_timer0_mode,
  input  wire logic       i_timer1_run,
  input  wire logic       i_timer1_counter_sel,
  input  wire logic [1:0] i_timer1_mode,
  // ****************************************
  // pins
  // ****************************************
  input  wire logic       i_timer0_count_input,
  input  wire logic       i_timer1_count_input,
  input  wire logic       i_timer2_count_input,
  input  wire logic       i_ext_irq0_input,
  // ****************************************
  // interrupt acknowledge and flags
  // ****************************************
  input  wire logic       i_irq_ack,
  output logic            o_timer0_overflow_flag,
  output logic            o_timer1_overflow_flag,
  output logic            o_timer2_overflow_flag,
  output logic [2:0]      o_machine_state,
  // ****************************************
  // overflow pulses and serial clocks
  // ****************************************
  output logic            o_timer0_overflow_pulse,
  output logic            o_timer1_overflow_pulse,
  output logic            o_serial_rx_clock,
  output logic            o_serial_tx_clock
);
  typedef struct packed {
    dtm_pkg::dtm_state_t state;
    logic [7:0] t0l;
    logic [7:0] t0h;
    logic [7:0] t1l;
    logic [7:0] t1h;
    logic       t0_carry;
    logic       t1_carry;
    logic       tf0;
    logic       tf1;
    logic       t0_pulse;
    logic       t1_pulse;
    logic [1:0] ack_cnt;
    logic       ack_pend;
    logic       cnt0_prev;
    logic       cnt1_prev;
    logic       cnt2_prev;
    logic       edge0;
    logic       edge1;
    logic [7:0] timer2_control;
    logic [7:0] timer2_mode_config;
    logic [7:0] rld_l;
    logic [7:0] rld_h;
    logic [15:0] t2cnt;
    logic       t2_pulse;
    logic [7:0] rdata;
  } dtm_timers_t;

  dtm_timers_t st_ff;
  dtm_timers_t nxt_st;
  logic [2:0]  pins_sync;
  logic        t0_en;
  logic        t1_en;
  logic        t2_baud;
  logic        t2_step;
  logic [15:0] t2_next;
  logic        t2_ovf;

  dtm_inc_if inc ();

  // ****************************************
  // shared incrementer and pin synchronisers
  // ****************************************
  dtm_incrementer u_inc (.inc(inc));

  dtm_sync #(.W(3)) u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_async   ({i_timer2_count_input, i_timer1_count_input, i_timer0_count_input}),
    .o_sync    (pins_sync)
  );

  // gate pin is only fed into the enable term after both stages
  logic irq0_s1_ff;
  logic irq0_ff;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      irq0_s1_ff <= 1'b0;
      irq0_ff    <= 1'b0;
    end
    else if (i_ce)
    begin
      irq0_s1_ff <= i_ext_irq0_input;
      irq0_ff    <= irq0_s1_ff;
    end
  end

  function automatic logic sfr_write(input logic [7:0] a, input logic [7:0] target);
    sfr_write = i_sfr_wr && (st_ff.state == dtm_pkg::ST_S6) && (a == target);
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    t0_en = i_timer0_run & (irq0_ff | ~i_timer0_gate_enable);
    t1_en = i_timer1_run && (i_timer1_mode != 2'h3);
    t2_baud = st_ff.timer2_control[dtm_pkg::T2C_RXSEL] | st_ff.timer2_control[dtm_pkg::T2C_TXSEL];
    inc.operand = st_ff.t0l;
    inc.enable  = 1'b0;
    nxt_st.t0_pulse = 1'b0;
    nxt_st.t1_pulse = 1'b0;
    nxt_st.t2_pulse = 1'b0;
    nxt_st.state = (st_ff.state == dtm_pkg::ST_S6) ? dtm_pkg::ST_S1
                 : dtm_pkg::dtm_state_t'(st_ff.state + 3'h1);
    case (st_ff.state)
      dtm_pkg::ST_S1:
      begin
        inc.operand = st_ff.t0l;
        inc.enable  = t0_en & (~i_timer0_counter_sel | st_ff.edge0);
        nxt_st.t0l  = inc.result;
        nxt_st.t0_carry = inc.overflow;
        if (inc.overflow && i_timer0_mode == 2'h2)
          nxt_st.t0l = st_ff.t0h;
      end
      dtm_pkg::ST_S2:
      begin
        inc.operand = st_ff.t0h;
        inc.enable  = st_ff.t0_carry && (i_timer0_mode != 2'h2);
        nxt_st.t0h  = inc.result;
        nxt_st.t0_pulse = inc.overflow;
        if (inc.overflow)
          nxt_st.tf0 = 1'b1;
        else if (st_ff.ack_pend)
          nxt_st.tf0 = 1'b0;
        // sample pins once per machine cycle
        nxt_st.cnt0_prev = pins_sync[0];
        nxt_st.edge0 = st_ff.cnt0_prev & ~pins_sync[0];
      end
      dtm_pkg::ST_S3:
      begin
        inc.operand = st_ff.t1l;
        inc.enable  = t1_en & (~i_timer1_counter_sel | st_ff.edge1);
        nxt_st.t1l  = inc.result;
        nxt_st.t1_carry = inc.overflow;
        if (inc.overflow && i_timer1_mode == 2'h2)
          nxt_st.t1l = st_ff.t1h;
      end
      dtm_pkg::ST_S4:
      begin
        inc.operand = st_ff.t1h;
        inc.enable  = st_ff.t1_carry && (i_timer1_mode != 2'h2);
        nxt_st.t1h  = inc.result;
        nxt_st.t1_pulse = inc.overflow;
        if (inc.overflow)
          nxt_st.tf1 = 1'b1;
        else if (st_ff.ack_cnt == 2'(dtm_pkg::ACK_T1_DELAY))
          nxt_st.tf1 = 1'b0;
        nxt_st.cnt1_prev = pins_sync[1];
        nxt_st.edge1 = st_ff.cnt1_prev & ~pins_sync[1];
      end
      default:
      begin
        inc.enable = 1'b0;
      end
    endcase
    // acknowledge: flag0 cleared at next S2, flag1 at the second S4 after it
    if (st_ff.state == dtm_pkg::ST_S2)
      nxt_st.ack_pend = 1'b0;
    if (st_ff.state == dtm_pkg::ST_S4 && st_ff.ack_cnt != 2'h0)
      nxt_st.ack_cnt = (st_ff.ack_cnt == 2'(dtm_pkg::ACK_T1_DELAY)) ? 2'h0
                     : 2'(st_ff.ack_cnt + 2'h1);
    if (i_irq_ack)
    begin
      nxt_st.ack_pend = 1'b1;
      nxt_st.ack_cnt  = 2'h1;
    end
    // low byte read clears the read flag; a hardware set below still wins
    if (i_sfr_rd && i_sfr_addr == dtm_pkg::ADDR_T2_CNT_L)
      nxt_st.timer2_mode_config[dtm_pkg::T2M_RD_FLAG] = 1'b0;
    // baud counter watches every clock, otherwise the pin is sampled in S1 only
    if (t2_baud || st_ff.state == dtm_pkg::ST_S1)
      nxt_st.cnt2_prev = pins_sync[2];
    if (t2_baud && st_ff.timer2_control[dtm_pkg::T2C_CNTSEL])
      t2_step = st_ff.cnt2_prev & ~pins_sync[2];
    else if (st_ff.timer2_control[dtm_pkg::T2C_CNTSEL])
      t2_step = (st_ff.state == dtm_pkg::ST_S1) & st_ff.cnt2_prev & ~pins_sync[2];
    else
      t2_step = (st_ff.state == dtm_pkg::ST_S1);
    t2_step = t2_step & st_ff.timer2_control[dtm_pkg::T2C_RUN];
    t2_ovf  = 1'b0;
    t2_next = st_ff.t2cnt;
    if (t2_step)
    begin
      if (t2_baud || st_ff.timer2_mode_config[dtm_pkg::T2M_DOWN_EN])
      begin
        t2_ovf  = (st_ff.t2cnt == 16'hffff);
        t2_next = t2_ovf ? {st_ff.rld_h, st_ff.rld_l} : 16'(st_ff.t2cnt + 16'h1);
      end
      else
      begin
        t2_ovf  = (st_ff.t2cnt == {st_ff.rld_h, st_ff.rld_l});
        t2_next = t2_ovf ? 16'hffff : 16'(st_ff.t2cnt - 16'h1);
      end
      if (t2_next[15:8] != st_ff.t2cnt[15:8])
        nxt_st.timer2_mode_config[dtm_pkg::T2M_RD_FLAG] = 1'b1;
    end
    nxt_st.t2cnt    = t2_next;
    nxt_st.t2_pulse = t2_ovf;
    if (t2_ovf && !t2_baud)
      nxt_st.timer2_control[dtm_pkg::T2C_OVF_BIT] = 1'b1;
    // firmware writes land in S6 and override hardware, except a timer2 overflow flag set
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T0_LOW))
      nxt_st.t0l = i_sfr_wdata;
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T0_HIGH))
      nxt_st.t0h = i_sfr_wdata;
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T1_LOW))
      nxt_st.t1l = i_sfr_wdata;
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T1_HIGH))
      nxt_st.t1h = i_sfr_wdata;
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T2_CTRL))
    begin
      // flag only clearable; reserved bit0 held at zero regardless
      // an overflow outside baud mode in the same cycle as a clearing write keeps the flag set
      nxt_st.timer2_control = (i_sfr_wdata & dtm_pkg::T2C_WMASK)
                   | {(st_ff.timer2_control[dtm_pkg::T2C_OVF_BIT] & i_sfr_wdata[dtm_pkg::T2C_OVF_BIT])
                      | (t2_ovf & ~t2_baud), 7'h00};
    end
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T2_MODE))
      nxt_st.timer2_mode_config = (nxt_st.timer2_mode_config & ~dtm_pkg::T2M_WMASK) | (i_sfr_wdata & dtm_pkg::T2M_WMASK);
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T2_RLD_L))
      nxt_st.rld_l = i_sfr_wdata;
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T2_RLD_H))
      nxt_st.rld_h = i_sfr_wdata;
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T2_CNT_L))
      nxt_st.t2cnt[7:0] = i_sfr_wdata;
    if (sfr_write(i_sfr_addr, dtm_pkg::ADDR_T2_CNT_H))
      nxt_st.t2cnt[15:8] = i_sfr_wdata;
    // read data
    case (i_sfr_addr)
      dtm_pkg::ADDR_T0_LOW:   nxt_st.rdata = st_ff.t0l;
      dtm_pkg::ADDR_T0_HIGH:  nxt_st.rdata = st_ff.t0h;
      dtm_pkg::ADDR_T1_LOW:   nxt_st.rdata = st_ff.t1l;
      dtm_pkg::ADDR_T1_HIGH:  nxt_st.rdata = st_ff.t1h;
      dtm_pkg::ADDR_T2_CTRL:  nxt_st.rdata = st_ff.timer2_control;
      dtm_pkg::ADDR_T2_MODE:  nxt_st.rdata = st_ff.timer2_mode_config;
      dtm_pkg::ADDR_T2_RLD_L: nxt_st.rdata = st_ff.rld_l;
      dtm_pkg::ADDR_T2_RLD_H: nxt_st.rdata = st_ff.rld_h;
      dtm_pkg::ADDR_T2_CNT_L: nxt_st.rdata = st_ff.t2cnt[7:0];
      dtm_pkg::ADDR_T2_CNT_H: nxt_st.rdata = st_ff.t2cnt[15:8];
      default:                nxt_st.rdata = dtm_pkg::RST_BYTE;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      st_ff       <= '0;
      st_ff.state <= dtm_pkg::ST_S1;
    end
    else if (i_ce)
      st_ff <= nxt_st;
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb
  begin
    o_sfr_hit = (i_sfr_addr >= dtm_pkg::ADDR_T0_LOW && i_sfr_addr <= dtm_pkg::ADDR_T1_HIGH)
             || (i_sfr_addr >= dtm_pkg::ADDR_T2_CTRL && i_sfr_addr <= dtm_pkg::ADDR_T2_CNT_H);
  end
  assign o_sfr_rdata             = st_ff.rdata;
  // flags sit stable for the interrupt controller's S2 scan
  assign o_timer0_overflow_flag  = st_ff.tf0;
  assign o_timer1_overflow_flag  = st_ff.tf1;
  assign o_timer2_overflow_flag  = st_ff.timer2_control[dtm_pkg::T2C_OVF_BIT];
  assign o_machine_state         = st_ff.state;
  assign o_timer0_overflow_pulse = st_ff.t0_pulse;
  assign o_timer1_overflow_pulse = st_ff.t1_pulse;
  assign o_serial_rx_clock = st_ff.timer2_control[dtm_pkg::T2C_RXSEL] ? st_ff.t2_pulse
                                                             : st_ff.t1_pulse;
  assign o_serial_tx_clock = st_ff.timer2_control[dtm_pkg::T2C_TXSEL] ? st_ff.t2_pulse
                                                             : st_ff.t1_pulse;
endmodule

// *** verif/dtm_timers_chk.sv ***
// dtm_timers_chk: port assertions for the timer block
`timescale 1ns/10ps
module dtm_timers_chk
(
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic       i_ce,
  // watched outputs
  input wire logic       o_sfr_hit,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic [2:0] o_machine_state,
  input wire logic       o_timer0_overflow_flag,
  input wire logic       o_timer1_overflow_flag,
  input wire logic       o_timer0_overflow_pulse,
  input wire logic       o_timer1_overflow_pulse
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  // ****************
  // machine cycle
  // ****************
  state_step_a: assert property (
    i_nrst && i_ce && o_machine_state != 3'h5 |=> o_machine_state == $past(o_machine_state) + 3'h1)
    else $error("machine state skipped");
  state_wrap_a: assert property (
    i_ce && o_machine_state == 3'h5 |=> o_machine_state == 3'h0)
    else $error("machine cycle not six states");
  state_hold_a: assert property (!i_ce |=> $stable(o_machine_state))
    else $error("state moved while frozen");
  // ****************
  // overflow flags, pulses and unmapped reads
  // ****************
  pulse0_slot_a: assert property (
    i_ce && o_timer0_overflow_pulse |->
      o_timer0_overflow_flag && o_machine_state == 3'h2 ##1 !o_timer0_overflow_pulse)
    else $error("timer0 pulse misplaced");
  pulse1_slot_a: assert property (
    i_ce && o_timer1_overflow_pulse |->
      o_timer1_overflow_flag && o_machine_state == 3'h4 ##1 !o_timer1_overflow_pulse)
    else $error("timer1 pulse misplaced");
  flag0_set_a: assert property (
    $rose(o_timer0_overflow_flag) |-> o_timer0_overflow_pulse && o_machine_state == 3'h2)
    else $error("timer0 flag set outside its state");
  flag1_set_a: assert property (
    $rose(o_timer1_overflow_flag) |-> o_timer1_overflow_pulse && o_machine_state == 3'h4)
    else $error("timer1 flag set outside its state");
  flag0_clr_a: assert property ($fell(o_timer0_overflow_flag) |-> o_machine_state == 3'h2)
    else $error("timer0 flag cleared outside its state");
  flag1_clr_a: assert property ($fell(o_timer1_overflow_flag) |-> o_machine_state == 3'h4)
    else $error("timer1 flag cleared outside its state");
  unmapped_a: assert property (i_ce && !o_sfr_hit |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (o_timer0_overflow_pulse);
  cover property (o_timer1_overflow_pulse);
  cover property ($fell(o_timer1_overflow_flag));
endmodule
bind dtm_timers dtm_timers_chk i_chk (.i_clk_sys, .i_nrst, .i_ce, .o_sfr_hit, .o_sfr_rdata,
  .o_machine_state, .o_timer0_overflow_flag, .o_timer1_overflow_flag,
  .o_timer0_overflow_pulse, .o_timer1_overflow_pulse);

// *** verif/test_dual_timer_and_reload_timer.sv ***
// test_dual_timer_and_reload_timer: self-checking bench for the timer block
`timescale 1ns/10ps
module test_dual_timer_and_reload_timer;
  logic       i_clk_sys, i_nrst, i_ce, i_sfr_wr, i_sfr_rd, i_irq_ack, take;
  logic       i_timer0_run, i_timer0_gate_enable, i_timer0_counter_sel;
  logic       i_timer1_run, i_timer1_counter_sel, i_ext_irq0_input;
  logic       i_timer0_count_input, i_timer1_count_input, i_timer2_count_input;
  logic [1:0] i_timer0_mode, i_timer1_mode;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, got, rnd;
  logic       o_sfr_hit, o_timer0_overflow_flag, o_timer1_overflow_flag;
  logic       o_timer2_overflow_flag, o_timer0_overflow_pulse, o_timer1_overflow_pulse;
  logic       o_serial_rx_clock, o_serial_tx_clock;
  logic [2:0] o_machine_state;
  logic [9:0] note;
  logic [9:0] exp_q[$];
  int         n_mismatch, samples_checked, rxn, txn, n;
  logic [7:0] regs[11] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hc9, 8'hca, 8'hcb,
                           8'hcc, 8'hcd, 8'h8e};
  logic [7:0] wmask[8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h7e, 8'h01, 8'hff, 8'hff};
  logic [7:0] b_mode[3] = '{8'h34, 8'h24, 8'h14};
  logic [7:0] b_exp[3]  = '{8'h03, 8'h02, 8'h01};
  logic [7:0] c_mode[2] = '{8'h06, 8'h36};

  dtm_timers i_dut (.i_clk_sys, .i_nrst, .i_ce, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
    .i_sfr_wdata, .o_sfr_rdata, .o_sfr_hit, .i_timer0_run, .i_timer0_gate_enable,
    .i_timer0_counter_sel, .i_timer0_mode, .i_timer1_run, .i_timer1_counter_sel,
    .i_timer1_mode, .i_timer0_count_input, .i_timer1_count_input, .i_timer2_count_input,
    .i_ext_irq0_input, .i_irq_ack, .o_timer0_overflow_flag, .o_timer1_overflow_flag,
    .o_timer2_overflow_flag, .o_machine_state, .o_timer0_overflow_pulse,
    .o_timer1_overflow_pulse, .o_serial_rx_clock, .o_serial_tx_clock);

  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // note goes in first, monitor compares at the next falling edge
  task automatic check(logic [9:0] e);
    exp_q.push_back(e);
    take <= 1'b1;
    @(posedge i_clk_sys);
    take <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  // writes land only on the edge leaving S6: see S5 settled, then drive at the next edge
  task automatic sfr_wr(logic [7:0] a, logic [7:0] d, logic [2:0] s = 3'h4);
    @(negedge i_clk_sys);
    while (o_machine_state !== s)
      @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    i_sfr_addr  <= a;
    i_sfr_wdata <= d;
    i_sfr_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_sfr_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic sfr_rd(logic [7:0] a, logic [7:0] e);
    i_sfr_addr <= a;
    i_sfr_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_sfr_rd <= 1'b0;
    check({2'h0, e});
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************
  // monitor and watchdog
  // ****************
  always @(negedge i_clk_sys)
  begin
    rxn = rxn + (o_serial_rx_clock === 1'b1);
    txn = txn + (o_serial_tx_clock === 1'b1);
    if (take === 1'b1)
    begin
      note = exp_q.pop_front();
      case (note[9:8])
        2'h0: got = o_sfr_rdata;
        2'h1: got = {5'h0, o_timer2_overflow_flag, o_timer1_overflow_flag,
                     o_timer0_overflow_flag};
        2'h3: got = {7'h0, o_sfr_hit};
        default: got = {6'h0, rxn != 0, txn != 0};
      endcase
      samples_checked++;
      if (got !== note[7:0])
      begin
        n_mismatch++;
        $display("[ERR] %0t got %h expected %h", $time, got, note[7:0]);
      end
    end
  end

  initial
  begin
    #40000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // ****************
  // tests
  // ****************
  initial
  begin
    {i_nrst, i_sfr_wr, i_sfr_rd, i_irq_ack, take, i_timer0_run, i_timer1_run} = '0;
    {i_timer0_gate_enable, i_timer0_counter_sel, i_timer1_counter_sel} = '0;
    {i_ext_irq0_input, i_sfr_addr, i_sfr_wdata} = '0;
    {i_timer0_count_input, i_timer1_count_input, i_timer2_count_input} = 3'h7;
    i_timer0_mode = 2'h1;
    i_timer1_mode = 2'h1;
    i_ce = 1'b1;
    rnd = 8'd42;
    repeat (10) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_ce <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_ce <= 1'b1;
    foreach (regs[k])
    begin
      sfr_rd(regs[k], 8'h00);
      check({2'h3, 7'h00, k < 10});
    end
    check({2'h1, 8'h00});
    $display("reset values done");
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      sfr_wr(regs[k], rnd & (k == 4 ? 8'hfa : 8'hff));
      sfr_rd(regs[k], rnd & (k == 4 ? 8'hfa : 8'hff) & wmask[k]);
    end
    $display("readback done");
    sfr_wr(8'h8a, 8'h00);
    sfr_wr(8'h8a, 8'h5a, 3'h1);
    sfr_rd(8'h8a, 8'h00);
    $display("write slot done");
    sfr_wr(8'h8c, 8'hff);
    sfr_wr(8'h8a, 8'hfd);
    i_timer0_gate_enable <= 1'b1;
    i_timer0_run <= 1'b1;
    repeat (24) @(posedge i_clk_sys);
    sfr_rd(8'h8a, 8'hfd);
    i_ext_irq0_input <= 1'b1;
    for (n = 0; n < 40 && o_timer0_overflow_pulse !== 1'b1; n++) @(posedge i_clk_sys);
    i_timer0_run <= 1'b0;
    check({2'h1, 8'h01});
    sfr_rd(8'h8a, 8'h00);
    sfr_rd(8'h8c, 8'h00);
    i_irq_ack <= 1'b1;
    @(posedge i_clk_sys);
    i_irq_ack <= 1'b0;
    repeat (12) @(posedge i_clk_sys);
    check({2'h1, 8'h00});
    $display("timer0 done");
    sfr_wr(8'h8d, 8'hff);
    sfr_wr(8'h8b, 8'hff);
    i_timer1_counter_sel <= 1'b1;
    i_timer1_run <= 1'b1;
    repeat (24) @(posedge i_clk_sys);
    sfr_rd(8'h8b, 8'hff);
    i_timer1_count_input <= 1'b0;
    for (n = 0; n < 40 && o_timer1_overflow_pulse !== 1'b1; n++) @(posedge i_clk_sys);
    i_timer1_run <= 1'b0;
    check({2'h1, 8'h02});
    i_irq_ack <= 1'b1;
    @(posedge i_clk_sys);
    i_irq_ack <= 1'b0;
    check({2'h1, 8'h02});
    repeat (24) @(posedge i_clk_sys);
    check({2'h1, 8'h00});
    i_timer1_count_input <= 1'b1;
    $display("timer1 done");
    sfr_wr(8'h8c, 8'hf0);
    sfr_wr(8'h8a, 8'hfe);
    i_timer0_mode <= 2'h2;
    i_timer1_mode <= 2'h3;
    i_timer1_counter_sel <= 1'b0;
    {i_timer0_run, i_timer1_run} <= 2'h3;
    repeat (21) @(posedge i_clk_sys);
    {i_timer0_run, i_timer1_run} <= 2'h0;
    sfr_rd(8'h8a, 8'hf1);
    sfr_rd(8'h8c, 8'hf0);
    sfr_rd(8'h8b, 8'h00);
    $display("reload modes done");
    sfr_wr(8'hc9, 8'h01);
    sfr_wr(8'hcc, 8'h00);
    sfr_wr(8'hcd, 8'h00);
    sfr_wr(8'hc8, 8'h04);
    repeat (3) sfr_wr(8'h8e, 8'h00);
    sfr_wr(8'hc8, 8'h00);
    sfr_rd(8'hcc, 8'h04);
    $display("timer2 rate done");
    sfr_wr(8'hca, 8'h34);
    sfr_wr(8'hcb, 8'h12);
    sfr_wr(8'hcd, 8'hff);
    sfr_wr(8'hcc, 8'hfe);
    sfr_wr(8'hc8, 8'h04);
    for (n = 0; n < 40 && o_timer2_overflow_flag !== 1'b1; n++) @(posedge i_clk_sys);
    check({2'h1, 8'h04});
    sfr_wr(8'hc8, 8'h00);
    sfr_rd(8'hcd, 8'h12);
    check({2'h1, 8'h00});
    $display("timer2 reload done");
    for (int k = 0; k < 3; k++)
    begin
      sfr_wr(8'hc8, 8'h00);
      sfr_wr(8'hcd, 8'hff);
      sfr_wr(8'hcc, 8'hfe);
      rxn = 0;
      txn = 0;
      sfr_wr(8'hc8, b_mode[k]);
      repeat (40) @(posedge i_clk_sys);
      check({2'h2, b_exp[k]});
      check({2'h1, 8'h00});
    end
    $display("baud done");
    foreach (c_mode[k])
    begin
      sfr_wr(8'hc8, 8'h00);
      sfr_wr(8'hcc, 8'h00);
      sfr_wr(8'hcd, 8'h00);
      sfr_wr(8'hc8, c_mode[k]);
      repeat (3)
      begin
        i_timer2_count_input <= 1'b0;
        repeat (12) @(posedge i_clk_sys);
        i_timer2_count_input <= 1'b1;
        repeat (12) @(posedge i_clk_sys);
      end
      sfr_wr(8'hc8, 8'h00);
      sfr_rd(8'hcc, 8'h03);
    end
    $display("timer2 counter done");
    end_of_test();
  end
endmodule
